/* hw/fqh_ctrl.sv */
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module fqh_ctrl
    import fqh_pkg::*;
(
    input  wire logic        CORE_CLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    output logic             SCK_O,
    output logic             CS_N_O,
    input  wire logic [3:0]  IO_I,
    output logic      [3:0]  IO_O,
    output logic      [3:0]  IO_OE_O
);

    fqh_state_t  state_ff;
    fqh_cmd_t    op_ff;
    fqh_cfg_t    cfg_ff;
    logic [31:0] addr_ff;
    logic [9:0]  len_ff;
    logic [9:0]  left_ff;
    logic        four_ff;
    logic        sck_ff;
    logic        cs_n_ff;
    logic [2:0]  hcnt_ff;
    logic [5:0]  cnt_ff;
    logic [3:0]  bcnt_ff;
    logic [31:0] sh_ff;
    logic [7:0]  rx_sh_ff;
    logic [7:0]  rx_data_ff;
    logic        rx_valid_ff;
    logic [7:0]  tx_data_ff;
    logic        tx_valid_ff;
    logic        need_ff;
    logic        skip_ff;
    logic        wen_seen_ff;
    logic        refused_ff;
    logic        wrap_ff;
    logic [7:0]  learn_ff;
    logic [31:0] prdata_ff;

    logic [3:0]  io_s;
    logic        wr;
    logic        rd;
    logic        start_req;
    logic        start_ok;
    fqh_cmd_t    cmd_w;
    logic        four_w;
    logic [7:0]  opcode;
    logic        active;
    logic        ddr;
    logic        w4;
    logic        stall;
    logic        run;
    logic        edge_t;
    logic        sample;
    logic [3:0]  epb;
    logic [5:0]  addr_nib;
    logic [7:0]  rx_next;
    logic [31:0] sh_shift;

    // ------------------------------------------------------------------
    // Pin synchronisers and APB decode
    // ------------------------------------------------------------------
    fqh_sync u_sync (
        .clk_i    (CORE_CLK_I),
        .arst_n_i (ARST_N_I),
        .d_i      (IO_I),
        .q_o      (io_s)
    );

    assign wr        = PSEL_I & PENABLE_I & PWRITE_I;
    assign rd        = PSEL_I & PENABLE_I & ~PWRITE_I;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ((PADDR_I > OFS_STATUS) | (PADDR_I[1:0] != 2'b00));
    assign PRDATA_O  = prdata_ff;
    assign cmd_w     = fqh_cmd_t'(PWDATA_I[1:0]);
    assign four_w    = PWDATA_I[CTRL_FOUR_BIT];
    assign start_req = wr && (PADDR_I == OFS_CTRL) && PWDATA_I[CTRL_START_BIT] && (state_ff == ST_IDLE);

    always_comb begin
        start_ok = start_req && (len_ff != 10'h000);
        case (cmd_w)
            CMD_READ: start_ok = start_ok && cfg_ff.quad_en;
            CMD_PROG: start_ok = start_ok && wen_seen_ff;
            default:  start_ok = start_ok;
        endcase
    end

    always_comb begin
        case (cmd_w)
            CMD_READ:     opcode = four_w ? OP_READ4 : OP_READ;
            CMD_PROG:     opcode = four_w ? OP_PROG4 : OP_PROG;
            CMD_WRITE_EN: opcode = OP_WRITE_ENABLE;
            default:      opcode = OP_STATUS_READ;
        endcase
    end

    // ------------------------------------------------------------------
    // Serial clock timing
    // ------------------------------------------------------------------
    assign active = (state_ff == ST_INSTR) || (state_ff == ST_ADDR) || (state_ff == ST_MODE) ||
                    (state_ff == ST_DUMMY) || (state_ff == ST_RDATA) || (state_ff == ST_WDATA);
    assign ddr    = (op_ff == CMD_READ) && (state_ff inside {ST_ADDR, ST_MODE, ST_DUMMY, ST_RDATA});
    assign w4     = ddr || cfg_ff.quad_peripheral_mode;
    assign stall  = ((state_ff == ST_WDATA) && need_ff) ||
                    ((state_ff == ST_RDATA) && rx_valid_ff && (bcnt_ff == 4'h1));
    assign run    = (active && !stall) || ((state_ff == ST_GAP) && sck_ff);
    assign edge_t = run && (hcnt_ff == HALF_LAST);
    assign sample = edge_t && active && (ddr ? !skip_ff : !sck_ff);
    assign epb      = w4 ? 4'h2 : 4'h8;
    assign addr_nib = four_ff ? 6'h08 : 6'h06;
    assign rx_next  = w4 ? {rx_sh_ff[3:0], io_s} : {rx_sh_ff[6:0], io_s[1]};
    assign sh_shift = w4 ? {sh_ff[27:0], 4'h0} : {sh_ff[30:0], 1'b0};

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            hcnt_ff <= 3'h0;
            sck_ff  <= 1'b0;
        end else begin
            if ((!run && state_ff != ST_HOLD) || hcnt_ff == HALF_LAST) begin
                hcnt_ff <= 3'h0;
            end else begin
                hcnt_ff <= hcnt_ff + 3'h1;
            end
            if (edge_t) begin
                sck_ff <= ~sck_ff;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cs_n_ff <= 1'b1;
        end else if (start_ok) begin
            cs_n_ff <= 1'b0;
        end else if (state_ff == ST_GAP && !sck_ff) begin
            cs_n_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_ff <= ST_IDLE;
            op_ff    <= CMD_READ;
            four_ff  <= 1'b0;
            sh_ff    <= 32'h0000_0000;
            cnt_ff   <= 6'h00;
            bcnt_ff  <= 4'h0;
            left_ff  <= 10'h000;
            rx_sh_ff <= 8'h00;
            need_ff  <= 1'b0;
            skip_ff  <= 1'b0;
        end else begin
            if (edge_t) begin
                skip_ff <= 1'b0;
            end
            case (state_ff)
                ST_IDLE: begin
                    if (start_ok) begin
                        state_ff <= ST_INSTR;
                        op_ff    <= cmd_w;
                        four_ff  <= four_w | cfg_ff.addr4;
                        sh_ff    <= {opcode, 24'h00_0000};
                        cnt_ff   <= cfg_ff.quad_peripheral_mode ? 6'h02 : 6'h08;
                        left_ff  <= len_ff;
                    end
                end
                ST_INSTR: begin
                    if (sample) begin
                        sh_ff  <= sh_shift;
                        cnt_ff <= cnt_ff - 6'h01;
                        if (cnt_ff == 6'h01) begin
                            sh_ff   <= four_ff ? addr_ff : {addr_ff[23:0], 8'h00};
                            cnt_ff  <= (op_ff == CMD_READ || cfg_ff.quad_peripheral_mode) ?
                                       addr_nib : {addr_nib[3:0], 2'b00};
                            bcnt_ff <= epb;
                            case (op_ff)
                                CMD_READ: begin
                                    state_ff <= ST_ADDR;
                                    skip_ff  <= 1'b1;
                                end
                                CMD_PROG:     state_ff <= ST_ADDR;
                                CMD_WRITE_EN: state_ff <= ST_GAP;
                                default:      state_ff <= ST_RDATA;
                            endcase
                        end
                    end
                end
                ST_ADDR: begin
                    if (sample) begin
                        sh_ff  <= sh_shift;
                        cnt_ff <= cnt_ff - 6'h01;
                        if (cnt_ff == 6'h01) begin
                            if (op_ff == CMD_READ) begin
                                state_ff <= ST_MODE;
                                sh_ff    <= {MODE_BITS, 24'h00_0000};
                                cnt_ff   <= 6'h02;
                            end else begin
                                state_ff <= ST_WDATA;
                                need_ff  <= 1'b1;
                                bcnt_ff  <= epb;
                            end
                        end
                    end
                end
                ST_MODE: begin
                    if (sample) begin
                        sh_ff  <= sh_shift;
                        cnt_ff <= cnt_ff - 6'h01;
                        if (cnt_ff == 6'h01) begin
                            bcnt_ff  <= 4'h2;
                            cnt_ff   <= {1'b0, cfg_ff.latency, 1'b0};
                            state_ff <= (cfg_ff.latency == 4'h0) ? ST_RDATA : ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (sample) begin
                        cnt_ff <= cnt_ff - 6'h01;
                        if (cnt_ff == 6'h01) begin
                            state_ff <= ST_RDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (sample) begin
                        rx_sh_ff <= rx_next;
                        bcnt_ff  <= bcnt_ff - 4'h1;
                        if (bcnt_ff == 4'h1) begin
                            bcnt_ff <= epb;
                            left_ff <= left_ff - 10'h001;
                            if (left_ff == 10'h001) begin
                                state_ff <= ST_GAP;
                            end
                        end
                    end
                end
                ST_WDATA: begin
                    if (need_ff) begin
                        if (tx_valid_ff) begin
                            sh_ff   <= {tx_data_ff, 24'h00_0000};
                            need_ff <= 1'b0;
                        end
                    end else if (sample) begin
                        sh_ff   <= sh_shift;
                        bcnt_ff <= bcnt_ff - 4'h1;
                        if (bcnt_ff == 4'h1) begin
                            bcnt_ff <= epb;
                            left_ff <= left_ff - 10'h001;
                            if (left_ff == 10'h001) begin
                                state_ff <= ST_GAP;
                            end else begin
                                need_ff <= 1'b1;
                            end
                        end
                    end
                end
                ST_GAP: begin
                    if (!sck_ff) begin
                        state_ff <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (hcnt_ff == HALF_LAST) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    assign SCK_O   = sck_ff;
    assign CS_N_O  = cs_n_ff;
    assign IO_O    = w4 ? sh_ff[31:28] : {3'b000, sh_ff[31]};
    assign IO_OE_O = (state_ff inside {ST_INSTR, ST_ADDR, ST_MODE, ST_WDATA}) ?
                     (w4 ? 4'hF : 4'h1) : 4'h0;

    // ------------------------------------------------------------------
    // Data registers and status
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rx_data_ff  <= 8'h00;
            rx_valid_ff <= 1'b0;
        end else if (state_ff == ST_RDATA && sample && bcnt_ff == 4'h1) begin
            rx_data_ff  <= rx_next;
            rx_valid_ff <= 1'b1;
        end else if (rd && PADDR_I == OFS_RDATA) begin
            rx_valid_ff <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tx_data_ff  <= 8'h00;
            tx_valid_ff <= 1'b0;
        end else if (wr && PADDR_I == OFS_WDATA) begin
            tx_data_ff  <= PWDATA_I[7:0];
            tx_valid_ff <= 1'b1;
        end else if (state_ff == ST_WDATA && need_ff && tx_valid_ff) begin
            tx_valid_ff <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wen_seen_ff <= 1'b0;
            refused_ff  <= 1'b0;
            wrap_ff     <= 1'b0;
        end else begin
            if (start_ok && cmd_w == CMD_PROG) begin
                wen_seen_ff <= 1'b0;
            end else if (state_ff == ST_GAP && !sck_ff && op_ff == CMD_WRITE_EN) begin
                wen_seen_ff <= 1'b1;
            end
            if (start_req) begin
                refused_ff <= !start_ok;
            end
            if (start_ok) begin
                wrap_ff <= (cmd_w == CMD_PROG) &&
                           (len_ff > (cfg_ff.page512 ? PAGE_LARGE : PAGE_SMALL));
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            learn_ff <= 8'h00;
        end else if (state_ff == ST_DUMMY && sample && cnt_ff <= LEARN_EDGES) begin
            learn_ff <= {learn_ff[6:0], io_s[0]};
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cfg_ff  <= fqh_cfg_t'(CFG_RESET);
            addr_ff <= 32'h0000_0000;
            len_ff  <= LEN_RESET;
        end else if (wr && state_ff == ST_IDLE) begin
            case (PADDR_I)
                OFS_CFG:  cfg_ff  <= fqh_cfg_t'(PWDATA_I[16:0]);
                OFS_ADDR: addr_ff <= PWDATA_I;
                OFS_LEN:  len_ff  <= PWDATA_I[9:0];
                default:  len_ff  <= len_ff;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            prdata_ff <= 32'h0000_0000;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            case (PADDR_I)
                OFS_CTRL:   prdata_ff <= {30'h0, op_ff};
                OFS_ADDR:   prdata_ff <= addr_ff;
                OFS_LEN:    prdata_ff <= {22'h0, len_ff};
                OFS_WDATA:  prdata_ff <= {24'h0, tx_data_ff};
                OFS_RDATA:  prdata_ff <= {24'h0, rx_data_ff};
                OFS_CFG:    prdata_ff <= {15'h0, cfg_ff};
                OFS_STATUS: prdata_ff <= {25'h0, wrap_ff, wen_seen_ff,
                                          cfg_ff.learn_en && (learn_ff == cfg_ff.learn_pattern),
                                          refused_ff, need_ff && !tx_valid_ff, rx_valid_ff,
                                          state_ff != ST_IDLE};
                default:    prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);

    sequence s_read_start;
        start_ok && cmd_w == CMD_READ;
    endsequence

    sequence s_mode_end;
        state_ff == ST_MODE && sample && cnt_ff == 6'h01 && cfg_ff.latency != 4'h0;
    endsequence

    sequence s_read_instr_end;
        state_ff == ST_INSTR && sample && cnt_ff == 6'h01 && op_ff == CMD_READ;
    endsequence

    a_sck_half: assert property ($rose(sck_ff) |-> sck_ff[*4])
        else $error("Serial clock high phase too short.");
    a_read_quad: assert property (s_read_start |-> cfg_ff.quad_en)
        else $error("Read started without quad enable.");
    a_read_opcode: assert property (s_read_start |=> sh_ff[31:24] == ($past(four_w) ? OP_READ4 : OP_READ))
        else $error("Wrong read opcode.");
    a_addr_edges: assert property (s_read_instr_end |=> state_ff == ST_ADDR && cnt_ff == (four_ff ? 6'h08 : 6'h06))
        else $error("Wrong address nibble count.");
    a_ddr_drive: assert property (state_ff == ST_ADDR && op_ff == CMD_READ |-> IO_OE_O == 4'hF)
        else $error("Address not driven on four lines.");
    a_mode_safe: assert property ($rose(state_ff == ST_MODE) |-> sh_ff[31:28] != ~sh_ff[27:24])
        else $error("Complementary mode nibbles.");
    a_dummy_len: assert property (s_mode_end |=> state_ff == ST_DUMMY && cnt_ff == {1'b0, cfg_ff.latency, 1'b0})
        else $error("Dummy length mismatch.");
    a_dummy_float: assert property (state_ff == ST_DUMMY |-> IO_OE_O == 4'h0 && !cs_n_ff)
        else $error("IO driven or select high in dummy.");
    a_prog_wen: assert property (start_ok && cmd_w == CMD_PROG |-> wen_seen_ff ##1 !wen_seen_ff)
        else $error("Program without write enable.");
    a_qpi_instr: assert property (start_ok && cfg_ff.quad_peripheral_mode |=> cnt_ff == 6'h02)
        else $error("Instruction not sent as nibbles.");
    a_cs_end: assert property ($rose(cs_n_ff) |-> $past(state_ff) == ST_GAP && !sck_ff &&
                              (left_ff == 10'h000 || op_ff == CMD_WRITE_EN))
        else $error("Select raised off a byte boundary.");

endmodule

/* pkg/fqh_pkg.sv */
package fqh_pkg;

    // ------------------------------------------------------------------
    // Clocking of the serial link
    // ------------------------------------------------------------------
    localparam int         CORE_MHZ        = 125;
    localparam int         SCK_MAX_MHZ     = 80;
    localparam int         SAMPLE_MIN_HALF = 4;
    localparam int         SCK_RATE_HALF   = (CORE_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
    localparam int         SCK_HALF_CYC    = (SCK_RATE_HALF > SAMPLE_MIN_HALF) ? SCK_RATE_HALF : SAMPLE_MIN_HALF;
    localparam logic [2:0] HALF_LAST       = 3'(SCK_HALF_CYC - 1);

    // ------------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_ADDR   = 8'h04;
    localparam logic [7:0] OFS_LEN    = 8'h08;
    localparam logic [7:0] OFS_WDATA  = 8'h0C;
    localparam logic [7:0] OFS_RDATA  = 8'h10;
    localparam logic [7:0] OFS_CFG    = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam int         CTRL_FOUR_BIT  = 2;
    localparam int         CTRL_START_BIT = 3;
    localparam logic [9:0] LEN_RESET  = 10'h001;
    localparam logic [16:0] CFG_RESET = 17'h0_6808;
    localparam logic [9:0] PAGE_SMALL = 10'h100;
    localparam logic [9:0] PAGE_LARGE = 10'h200;
    localparam logic [5:0] LEARN_EDGES = 6'h08;

    // ------------------------------------------------------------------
    // Opcodes and fixed values sent to the flash
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_READ         = 8'hED;
    localparam logic [7:0] OP_READ4        = 8'hEE;
    localparam logic [7:0] OP_PROG         = 8'h02;
    localparam logic [7:0] OP_PROG4        = 8'h12;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] MODE_BITS       = 8'h00;

    typedef enum logic [1:0] {
        CMD_READ     = 2'h0,
        CMD_PROG     = 2'h1,
        CMD_WRITE_EN = 2'h2,
        CMD_STATUS   = 2'h3
    } fqh_cmd_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_INSTR, ST_ADDR, ST_MODE, ST_DUMMY, ST_RDATA, ST_WDATA, ST_GAP, ST_HOLD
    } fqh_state_t;

    typedef struct packed {
        logic [7:0] learn_pattern;
        logic       page512;
        logic       learn_en;
        logic       quad_peripheral_mode;
        logic       addr4;
        logic       quad_en;
        logic [3:0] latency;
    } fqh_cfg_t;

endpackage

/* hw/fqh_sync.sv */
`timescale 1ns/1ns
module fqh_sync
    import fqh_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [3:0] d_i,
    output logic      [3:0] q_o
);

    // ------------------------------------------------------------------
    // Two-stage synchroniser per pin
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_bit
            logic meta_ff;
            logic sync_ff;
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                end else begin
                    meta_ff <= d_i[g];
                    sync_ff <= meta_ff;
                end
            end
            assign q_o[g] = sync_ff;
        end
    endgenerate

endmodule

/* tb/fqh_flash_model.sv */
`timescale 1ns/1ns
module fqh_flash_model
    import fqh_pkg::*;
#(
    parameter int LAT = 8
)(
    input  wire logic       sck_i,
    input  wire logic       cs_n_i,
    output logic      [3:0] io_o
);
    localparam int         D     = 24 + 2 * LAT;
    localparam logic [7:0] LEARN = 8'h34;
    int         e;
    logic [7:0] b;
    initial begin
        e = 0;
        io_o = 4'h5;
    end
    // Released lines show the inverse of the last value, never a stale copy.
    always @(posedge cs_n_i) io_o = ~io_o;
    always @(negedge cs_n_i) e = 0;
    always @(sck_i) begin
        if (!cs_n_i) begin
            e = e + 1;
            b = 8'hC0 + 8'((e - D) / 2);
            if (e >= D - 8 && e < D) begin
                io_o = {4{LEARN[D-1-e]}};
            end else if (e >= D) begin
                io_o = e[0] ? b[3:0] : b[7:4];
            end else begin
                io_o = ~io_o;
            end
        end
    end
endmodule

/* tb/test_fqh_ctrl.sv */
`timescale 1ns/1ns
module test_fqh_ctrl
    import fqh_pkg::*;
;
    logic        clk, rst_n, psel, pen, pwr, pready, pslverr, sck, cs_n;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  io_o, io_oe, mio;
    logic        e;
    int          error_cnt, samples_checked, cyc, sck_e, oe_bad;
    logic [7:0]  ra [4] = '{OFS_CFG, OFS_LEN, OFS_STATUS, 8'h1C};
    logic [32:0] rx [4] = '{33'h0_0000_6808, 33'h0_0000_0001, 33'h0, 33'h1_0000_0000};
    fqh_ctrl dut (.CORE_CLK_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .SCK_O(sck), .CS_N_O(cs_n), .IO_I((io_oe & io_o) | (~io_oe & mio)), .IO_O(io_o), .IO_OE_O(io_oe));
    fqh_flash_model #(.LAT(8)) u_flash (.sck_i(sck), .cs_n_i(cs_n), .io_o(mio));
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    always @(negedge cs_n) sck_e = 0;
    always @(sck) if (!cs_n) sck_e++;
    always @(posedge clk) begin
        cyc++;
        if (!cs_n && sck_e > 24 && io_oe !== 4'h0) oe_bad++;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    task automatic poll(input int bit_i, input logic v);
        do apb(0, OFS_STATUS, 0); while (r[bit_i] !== v);
    endtask
    initial begin
        {psel, pen, pwr, paddr, pwdata, error_cnt, samples_checked, cyc, sck_e, oe_bad} = '0;
        rst_n = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            apb(0, ra[i], 0);
            chk({e, r}, rx[i]);
        end
        $display("test registers done");
        apb(1, OFS_CTRL, 32'h0000_0008);
        poll(0, 0);
        chk(r[3], 1);
        apb(1, OFS_CTRL, 32'h0000_0009);
        poll(0, 0);
        chk(r[3], 1);
        $display("test refusals done");
        apb(1, OFS_CFG, 32'h0000_6898);
        apb(1, OFS_ADDR, 32'h0000_0010);
        apb(1, OFS_LEN, 32'h0000_0002);
        apb(1, OFS_CTRL, 32'h0000_0008);
        for (int k = 0; k < 2; k++) begin
            poll(1, 1);
            apb(0, OFS_RDATA, 0);
            chk(r, 32'h0000_00C0 + k);
        end
        poll(0, 0);
        chk(r[4], 1);
        chk(r[3], 0);
        chk(sck_e, 24 + 2 * 8 + 4);
        chk(oe_bad, 0);
        $display("test ddr read done");
        apb(1, OFS_CTRL, 32'h0000_000A);
        poll(0, 0);
        chk(r[5], 1);
        chk(sck_e, 16);
        apb(1, OFS_LEN, 32'h0000_0001);
        apb(1, OFS_WDATA, 32'h0000_00A5);
        apb(1, OFS_CTRL, 32'h0000_0009);
        poll(0, 0);
        chk({r[6:5], r[3]}, 0);
        chk(sck_e, 80);
        apb(0, OFS_CTRL, 0);
        chk(r, 32'h0000_0001);
        $display("test program done");
        rst_n <= 0;
        repeat (2) @(posedge clk);
        chk({cs_n, sck}, 2'b10);
        rst_n <= 1;
        @(posedge clk);
        apb(0, OFS_STATUS, 0);
        chk(r, 0);
        apb(0, OFS_CFG, 0);
        chk({e, r}, rx[0]);
        $display("test reset done");
        end_sim();
    end
endmodule
